// File: htcw_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef HTCW_REGS_VH
`define HTCW_REGS_VH

// ==========================================================================
// Register byte offsets
`define HTCW_TMR_CFG_OFS 8'h8c
`define HTCW_TMR_COUNT_OFS 8'h90
`define HTCW_WORD_ORDER_OFS 8'h98
`define HTCW_FREE_TICK_OFS 8'h9c
`define HTCW_RX_DISCARD_OFS 8'ha0

// ==========================================================================
// Field positions
`define HTCW_GPT_EN_BIT 29
`define HTCW_PRELOAD_MSB 15
`define HTCW_PRELOAD_LSB 0

// ==========================================================================
// Reset values and patterns
`define HTCW_PRELOAD_RST 16'hffff
`define HTCW_TMR_COUNT_RST 16'hffff
`define HTCW_WORD_ORDER_RST 32'h00000000
`define HTCW_SWAP_PATTERN 32'hffffffff
`define HTCW_FREE_TICK_RST 32'h00000000
`define HTCW_RX_DISCARD_RST 32'h00000000
`define HTCW_RX_HALFWAY_FROM 32'h7fffffff
`define HTCW_RX_HALFWAY_TO 32'h80000000
`define HTCW_UNMAPPED_DATA 16'h0000

// ==========================================================================
// Timing
`define HTCW_CLK_PERIOD_NS 40
`define HTCW_GPT_TICK_NS 100000
`define HTCW_GPT_TICK_CYCLES (`HTCW_GPT_TICK_NS / `HTCW_CLK_PERIOD_NS)
`define HTCW_FREE_CLR_NS 160
`define HTCW_FREE_CLR_CYCLES ((`HTCW_FREE_CLR_NS + `HTCW_CLK_PERIOD_NS - 1) / `HTCW_CLK_PERIOD_NS)

`endif

// File: htcw_gptimer.v
// General purpose down-counting timer with its tick divider
`timescale 1ns/1ps
`default_nettype none
`include "htcw_regs.vh"

module htcw_gptimer (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [15:0] preload,
    output reg [15:0] count_r,
    output reg wrap_r
);

    // Divider wraps once per timer tick
    localparam integer TICK_LAST_INT = `HTCW_GPT_TICK_CYCLES - 1;
    localparam [11:0] TICK_LAST = TICK_LAST_INT[11:0];

    reg [11:0] div_r;
    reg run_d_r;
    wire tick;
    wire start;

    assign tick = (div_r == TICK_LAST);
    assign start = run & ~run_d_r;

    // ======================================================================
    // Tick divider, restarted on every run start
    always @(posedge clk) begin
        if (rst) begin
            div_r <= 12'h000;
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run;
            if (start || !run || tick) begin
                div_r <= 12'h000;
            end else begin
                div_r <= div_r + 12'h001;
            end
        end
    end

    // ======================================================================
    // Count down, reload and flag on passing zero
    always @(posedge clk) begin
        if (rst) begin
            count_r <= `HTCW_TMR_COUNT_RST;
            wrap_r <= 1'b0;
        end else begin
            wrap_r <= 1'b0;
            if (start) begin
                count_r <= preload;
            end else if (run && tick) begin
                if (count_r == 16'h0000) begin
                    count_r <= preload;
                    wrap_r <= 1'b1;
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: htcw_lane.v
// Half-word ordering between data FIFO words and the network side
`timescale 1ns/1ps
`default_nettype none

module htcw_lane (
    input wire clk,
    input wire rst,
    input wire rxh_valid,
    input wire [15:0] rxh_data,
    output reg rxw_valid_r,
    output reg [31:0] rxw_data_r,
    input wire txw_valid,
    input wire [31:0] txw_data,
    output wire txw_ready,
    output wire txh_valid,
    output reg [15:0] txh_data_r,
    input wire txh_ready
);

    reg rx_half_r;
    reg [15:0] rx_low_r;
    reg tx_busy_r;
    reg tx_phase_r;
    reg [15:0] tx_high_r;

    assign txw_ready = ~tx_busy_r;
    assign txh_valid = tx_busy_r;

    // ======================================================================
    // Receive: first half lands in the low half of the word
    always @(posedge clk) begin
        if (rst) begin
            rx_half_r <= 1'b0;
            rx_low_r <= 16'h0000;
            rxw_valid_r <= 1'b0;
            rxw_data_r <= 32'h00000000;
        end else begin
            rxw_valid_r <= 1'b0;
            if (rxh_valid) begin
                if (!rx_half_r) begin
                    rx_low_r <= rxh_data;
                    rx_half_r <= 1'b1;
                end else begin
                    rxw_data_r <= {rxh_data, rx_low_r};
                    rxw_valid_r <= 1'b1;
                    rx_half_r <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Transmit: low half goes out first
    always @(posedge clk) begin
        if (rst) begin
            tx_busy_r <= 1'b0;
            tx_phase_r <= 1'b0;
            tx_high_r <= 16'h0000;
            txh_data_r <= 16'h0000;
        end else if (!tx_busy_r) begin
            if (txw_valid) begin
                txh_data_r <= txw_data[15:0];
                tx_high_r <= txw_data[31:16];
                tx_busy_r <= 1'b1;
                tx_phase_r <= 1'b0;
            end
        end else if (txh_ready) begin
            if (!tx_phase_r) begin
                txh_data_r <= tx_high_r;
                tx_phase_r <= 1'b1;
            end else begin
                tx_busy_r <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: htcw_top.v
// Host timers, counters and word order control behind a 16-bit host bus
`timescale 1ns/1ps
`default_nettype none
`include "htcw_regs.vh"

module htcw_top (
    input wire CLK,
    input wire RST,
    input wire CS_N,
    input wire RD_N,
    input wire WR_N,
    input wire [7:1] ADDR,
    input wire [15:0] DATA_IN,
    output reg [15:0] DATA_OUT,
    output reg DATA_OE,
    output wire UPPER_HALF_SEL,
    input wire RX_FRAME_DROPPED,
    output reg GPT_EVENT,
    output reg RX_HALFWAY_EVENT,
    input wire RXH_VALID,
    input wire [15:0] RXH_DATA,
    output wire RXW_VALID,
    output wire [31:0] RXW_DATA,
    input wire TXW_VALID,
    input wire [31:0] TXW_DATA,
    output wire TXW_READY,
    output wire TXH_VALID,
    output wire [15:0] TXH_DATA,
    input wire TXH_READY
);

    // ======================================================================
    // Helpers

    // Picks one 16-bit half of a word
    function [15:0] htcw_half;
        input [31:0] word;
        input upper;
        begin
            if (upper) begin
                htcw_half = word[31:16];
            end else begin
                htcw_half = word[15:0];
            end
        end
    endfunction

    // Replaces one 16-bit half of a word
    function [31:0] htcw_merge;
        input [31:0] word;
        input upper;
        input [15:0] data;
        begin
            if (upper) begin
                htcw_merge = {data, word[15:0]};
            end else begin
                htcw_merge = {word[31:16], data};
            end
        end
    endfunction

    // ======================================================================
    // Host bus strobes

    reg rd_act_d_r;
    reg wr_act_d_r;
    wire rd_act;
    wire wr_act;
    wire rd_start;
    wire wr_start;
    wire [7:0] byte_ofs;

    assign rd_act = ~CS_N & ~RD_N;
    assign wr_act = ~CS_N & ~WR_N;
    assign rd_start = rd_act & ~rd_act_d_r;
    assign wr_start = wr_act & ~wr_act_d_r & ~rd_act;
    assign byte_ofs = {ADDR[7:2], 2'b00};

    always @(posedge CLK) begin
        if (RST) begin
            rd_act_d_r <= 1'b0;
            wr_act_d_r <= 1'b0;
        end else begin
            rd_act_d_r <= rd_act;
            wr_act_d_r <= wr_act;
        end
    end

    // ======================================================================
    // Word order

    reg [31:0] word_order_r;
    wire swap;
    wire upper;

    assign swap = (word_order_r == `HTCW_SWAP_PATTERN);
    // Address bit one selects the internal half, inverted under swap
    assign upper = ADDR[1] ^ swap;
    assign UPPER_HALF_SEL = upper;

    // ======================================================================
    // Address decode

    reg sel_cfg;
    reg sel_cnt;
    reg sel_word;
    reg sel_free;
    reg sel_drop;

    always @* begin
        sel_cfg = 1'b0;
        sel_cnt = 1'b0;
        sel_word = 1'b0;
        sel_free = 1'b0;
        sel_drop = 1'b0;
        if (byte_ofs == `HTCW_TMR_CFG_OFS) begin
            sel_cfg = 1'b1;
        end else if (byte_ofs == `HTCW_TMR_COUNT_OFS) begin
            sel_cnt = 1'b1;
        end else if (byte_ofs == `HTCW_WORD_ORDER_OFS) begin
            sel_word = 1'b1;
        end else if (byte_ofs == `HTCW_FREE_TICK_OFS) begin
            sel_free = 1'b1;
        end else if (byte_ofs == `HTCW_RX_DISCARD_OFS) begin
            sel_drop = 1'b1;
        end
    end

    // ======================================================================
    // Timer configuration

    reg timer_run_r;
    reg [15:0] timer_preload_value_r;
    reg [31:0] cfg_nxt;
    wire [31:0] gp_timer_config;
    wire [15:0] timer_current_count;
    wire gpt_wrap;

    // Reserved bits stay zero in the assembled register
    assign gp_timer_config = {2'b00, timer_run_r, 13'h0000,
        timer_preload_value_r};

    always @* begin
        cfg_nxt = htcw_merge(gp_timer_config, upper, DATA_IN);
    end

    always @(posedge CLK) begin
        if (RST) begin
            timer_run_r <= 1'b0;
            timer_preload_value_r <= `HTCW_PRELOAD_RST;
        end else if (wr_start && sel_cfg) begin
            timer_run_r <= cfg_nxt[`HTCW_GPT_EN_BIT];
            if (timer_run_r && !cfg_nxt[`HTCW_GPT_EN_BIT]) begin
                timer_preload_value_r <= `HTCW_PRELOAD_RST;
            end else begin
                timer_preload_value_r <=
                    cfg_nxt[`HTCW_PRELOAD_MSB:`HTCW_PRELOAD_LSB];
            end
        end
    end

    htcw_gptimer u_timer (
        .clk(CLK),
        .rst(RST),
        .run(timer_run_r),
        .preload(timer_preload_value_r),
        .count_r(timer_current_count),
        .wrap_r(gpt_wrap)
    );

    // ======================================================================
    // Word order register

    always @(posedge CLK) begin
        if (RST) begin
            word_order_r <= `HTCW_WORD_ORDER_RST;
        end else if (wr_start && sel_word) begin
            word_order_r <= htcw_merge(word_order_r, upper, DATA_IN);
        end
    end

    // ======================================================================
    // Free tick counter, not gated by any power state

    reg [31:0] free_tick_count_r;
    reg [31:0] free_snap_r;
    reg free_pend_r;

    always @(posedge CLK) begin
        if (RST) begin
            free_tick_count_r <= `HTCW_FREE_TICK_RST;
        end else begin
            free_tick_count_r <= free_tick_count_r + 32'h00000001;
        end
    end

    // First half read freezes the whole value for the second
    always @(posedge CLK) begin
        if (RST) begin
            free_snap_r <= 32'h00000000;
            free_pend_r <= 1'b0;
        end else if (rd_start && sel_free) begin
            if (!free_pend_r) begin
                free_snap_r <= free_tick_count_r;
                free_pend_r <= 1'b1;
            end else begin
                free_pend_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Dropped frame tally

    reg [31:0] dropped_frame_tally_r;
    reg [31:0] tally_nxt;
    reg [31:0] drop_snap_r;
    reg drop_pend_r;
    wire drop_clear;

    // Only the first half read clears; the second reads the frozen value
    assign drop_clear = rd_start & sel_drop & ~drop_pend_r;

    // A frame dropped in the clearing cycle is kept
    always @* begin
        tally_nxt = dropped_frame_tally_r;
        if (drop_clear) begin
            tally_nxt = `HTCW_RX_DISCARD_RST;
        end
        if (RX_FRAME_DROPPED) begin
            tally_nxt = tally_nxt + 32'h00000001;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            dropped_frame_tally_r <= `HTCW_RX_DISCARD_RST;
            drop_snap_r <= 32'h00000000;
            drop_pend_r <= 1'b0;
            RX_HALFWAY_EVENT <= 1'b0;
        end else begin
            dropped_frame_tally_r <= tally_nxt;
            RX_HALFWAY_EVENT <= (dropped_frame_tally_r == `HTCW_RX_HALFWAY_FROM) &&
                (tally_nxt == `HTCW_RX_HALFWAY_TO);
            if (rd_start && sel_drop) begin
                if (!drop_pend_r) begin
                    drop_snap_r <= dropped_frame_tally_r;
                    drop_pend_r <= 1'b1;
                end else begin
                    drop_pend_r <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Timer event

    always @(posedge CLK) begin
        if (RST) begin
            GPT_EVENT <= 1'b0;
        end else begin
            GPT_EVENT <= gpt_wrap;
        end
    end

    // ======================================================================
    // Read data

    reg [15:0] rd_half;

    always @* begin
        rd_half = `HTCW_UNMAPPED_DATA;
        if (sel_cfg) begin
            rd_half = htcw_half(gp_timer_config, upper);
        end else if (sel_cnt) begin
            rd_half = htcw_half({16'h0000, timer_current_count}, upper);
        end else if (sel_word) begin
            rd_half = htcw_half(word_order_r, upper);
        end else if (sel_free) begin
            if (free_pend_r) begin
                rd_half = htcw_half(free_snap_r, upper);
            end else begin
                rd_half = htcw_half(free_tick_count_r, upper);
            end
        end else if (sel_drop) begin
            if (drop_pend_r) begin
                rd_half = htcw_half(drop_snap_r, upper);
            end else begin
                rd_half = htcw_half(dropped_frame_tally_r, upper);
            end
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            DATA_OUT <= 16'h0000;
            DATA_OE <= 1'b0;
        end else begin
            DATA_OE <= rd_act;
            if (rd_start) begin
                DATA_OUT <= rd_half;
            end
        end
    end

    // ======================================================================
    // Data FIFO half ordering to and from the network

    htcw_lane u_lane (
        .clk(CLK),
        .rst(RST),
        .rxh_valid(RXH_VALID),
        .rxh_data(RXH_DATA),
        .rxw_valid_r(RXW_VALID),
        .rxw_data_r(RXW_DATA),
        .txw_valid(TXW_VALID),
        .txw_data(TXW_DATA),
        .txw_ready(TXW_READY),
        .txh_valid(TXH_VALID),
        .txh_data_r(TXH_DATA),
        .txh_ready(TXH_READY)
    );

endmodule

`default_nettype wire

// File: htcw_props.sv
// Port-level assertions for the host timers, counters and word order block
`timescale 1ns/1ps
`default_nettype none
module htcw_props (
    input wire CLK,
    input wire RST,
    input wire CS_N,
    input wire RD_N,
    input wire [15:0] DATA_OUT,
    input wire DATA_OE,
    input wire GPT_EVENT,
    input wire RXH_VALID,
    input wire [15:0] RXH_DATA,
    input wire RXW_VALID,
    input wire [31:0] RXW_DATA,
    input wire TXW_VALID,
    input wire [31:0] TXW_DATA,
    input wire TXW_READY,
    input wire TXH_VALID,
    input wire [15:0] TXH_DATA,
    input wire TXH_READY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire rd = !CS_N && !RD_N;
    reg rd_r;
    reg rx_odd_r;
    reg tx_second_r;
    reg [15:0] rx_first_r;
    reg [15:0] tx_lo_r;
    reg [15:0] tx_hi_r;
    // ==========================================================
    // Helper state: access start, half pairing, transmit halves
    always @(posedge CLK) begin
        if (RST) begin
            rd_r <= 1'b0;
            rx_odd_r <= 1'b0;
            tx_second_r <= 1'b0;
        end else begin
            rd_r <= rd;
            if (RXH_VALID) rx_odd_r <= !rx_odd_r;
            if (TXH_VALID && TXH_READY) tx_second_r <= !tx_second_r;
        end
        if (RXH_VALID && !rx_odd_r) rx_first_r <= RXH_DATA;
        if (TXW_VALID && TXW_READY) tx_lo_r <= TXW_DATA[15:0];
        if (TXW_VALID && TXW_READY) tx_hi_r <= TXW_DATA[31:16];
    end
    // ==========================================================
    // Assertions
    a_oe_on_read: assert property (rd && !rd_r |=> DATA_OE)
        else $error("output enable missing after read start");
    a_oe_release: assert property (!rd |=> !DATA_OE)
        else $error("output enable held without a read");
    a_data_hold: assert property (!(rd && !rd_r) |=> $stable(DATA_OUT))
        else $error("read data changed without a read start");
    a_gpt_single: assert property (GPT_EVENT |=> !GPT_EVENT [*8])
        else $error("timer event longer than one cycle");
    a_rx_word: assert property (RXH_VALID && rx_odd_r |=>
        RXW_VALID && RXW_DATA == {$past(RXH_DATA), rx_first_r})
        else $error("receive word wrong or missing");
    a_rx_quiet: assert property (!(RXH_VALID && rx_odd_r) |=> !RXW_VALID)
        else $error("receive word without a second half");
    a_tx_low_first: assert property (TXW_VALID && TXW_READY |=>
        TXH_VALID && !TXW_READY && TXH_DATA == tx_lo_r)
        else $error("transmit did not start with the low half");
    a_tx_high_next: assert property (TXH_VALID && TXH_READY && !tx_second_r |=>
        TXH_VALID && TXH_DATA == tx_hi_r)
        else $error("transmit high half missing");
    a_tx_word_done: assert property (TXH_VALID && TXH_READY && tx_second_r |=>
        TXW_READY && !TXH_VALID)
        else $error("transmit did not rearm after two halves");
    a_tx_stall: assert property (TXH_VALID && !TXH_READY |=> TXH_VALID && $stable(TXH_DATA))
        else $error("transmit half dropped while stalled");
endmodule
`default_nettype wire

// File: htcw_host.sv
// Host processor model driving half-word accesses on the SRAM-like bus
`timescale 1ns/1ps
`default_nettype none
module htcw_host (
    input wire logic clk,
    input wire logic rst,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:1] addr,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 7'h00;
        wdata = 16'h0000;
    end
    // Wait out the counter clear time after reset
    task automatic settle();
        while (rst) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask
    // One half-word access, held for two edges, then one idle cycle
    task automatic acc(input logic [7:0] ofs, input logic wr, input logic [15:0] d,
            output logic [15:0] q);
        @(posedge clk);
        #1;
        addr = ofs[7:1];
        wdata = d;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        repeat (2) @(posedge clk);
        q = rdata;
        #1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = ~addr;
        wdata = ~wdata;
    endtask
endmodule
`default_nettype wire

// File: host_timers_counters_word_order_test.sv
// Self-checking bench for the host timers, counters and word order block
`timescale 1ns/1ps
`default_nettype none
`include "htcw_regs.vh"
module host_timers_counters_word_order_test;
    localparam logic [16:0] DC = 17'h10000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic drop = 1'b0;
    logic rxh_v = 1'b0;
    logic [15:0] rxh_d = 16'h0000;
    logic txw_v = 1'b0;
    logic [31:0] txw_d = 32'h00000000;
    logic txh_rdy = 1'b0;
    logic oe_q = 1'b0;
    logic swp = 1'b0;
    logic half_seen = 1'b0;
    wire logic cs_n, rd_n, wr_n, oe, uhs, gpt_ev, half_ev, rxw_v, txw_rdy, txh_v;
    wire logic [7:1] addr;
    wire logic [15:0] din, dout, txh_d;
    wire logic [31:0] rxw_d;
    integer n_mismatch = 0;
    integer total_checks = 0;
    integer seed = 32'h9aa0;
    int cyc = 0;
    logic [16:0] rdq[$];
    logic [31:0] rxq[$];
    logic [15:0] txq[$];
    int evq[$];
    logic [7:0] ofs_tab [10] = '{8'h8c, 8'h8e, 8'h90, 8'h92, 8'h98, 8'h9a, 8'ha0, 8'ha2,
        8'h80, 8'hbe};
    logic [15:0] rst_tab [10] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    htcw_top DUT (.CLK(clk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .ADDR(addr),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .UPPER_HALF_SEL(uhs),
        .RX_FRAME_DROPPED(drop), .GPT_EVENT(gpt_ev), .RX_HALFWAY_EVENT(half_ev),
        .RXH_VALID(rxh_v), .RXH_DATA(rxh_d), .RXW_VALID(rxw_v), .RXW_DATA(rxw_d),
        .TXW_VALID(txw_v), .TXW_DATA(txw_d), .TXW_READY(txw_rdy), .TXH_VALID(txh_v),
        .TXH_DATA(txh_d), .TXH_READY(txh_rdy));
    htcw_host host (.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .wdata(din), .rdata(dout));

    always #20 clk = ~clk;
    // ==========================================================
    // Cycle count, timeout and random transmit back-pressure
    always @(posedge clk) begin
        cyc <= rst ? 0 : cyc + 1;
        #1 txh_rdy = 1'($random(seed));
        if (cyc == 60000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [16:0] exp, output logic [15:0] q);
        rdq.push_back(exp);
        host.acc(ofs, 1'b0, 16'h0000, q);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [15:0] d);
        logic [15:0] q;
        host.acc(ofs, 1'b1, d, q);
    endtask
    // ==========================================================
    // Output monitor: oldest note against each result
    always @(negedge clk) begin
        if (oe && !oe_q) begin
            check("upper half select", {31'h0, uhs}, {31'h0, addr[1] ^ swp});
            if (rdq.size() == 0) check("read with no note", 32'h0, 32'h1);
            else if (!rdq[0][16]) check("read data", {16'h0, dout}, {16'h0, rdq[0][15:0]});
            if (rdq.size() > 0) void'(rdq.pop_front());
        end
        oe_q <= oe;
        if (gpt_ev) evq.push_back(cyc);
        if (half_ev) half_seen <= 1'b1;
        if (rxw_v) check("rx word", rxw_d, rxq.pop_front());
        if (txh_v && txh_rdy) check("tx half", {16'h0, txh_d}, {16'h0, txq.pop_front()});
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] q, a, b, c;
        int n;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        host.settle();
        rd(8'h9c, DC, a);
        rd(8'h9c, DC, b);
        rd(8'h9c, DC, c);
        check("free count frozen", b, a);
        check("free count step", 16'(c - a), 32'd6);
        check("free count early", 32'(a < 16'd40), 32'd1);
        for (int i = 0; i < 10; i++) rd(ofs_tab[i], {1'b0, rst_tab[i]}, q);
        n = 1 + ($random(seed) & 15);
        @(posedge clk);
        #1 drop = 1'b1;
        repeat (n) @(posedge clk);
        #1 drop = 1'b0;
        rd(8'ha0, {1'b0, 16'(n)}, q);
        rd(8'ha2, 17'h00000, q);
        rd(8'ha0, 17'h00000, q);
        wr(8'h8c, 16'h0003);
        wr(8'h8e, 16'hffff);
        rd(8'h8e, 17'h02000, q);
        rd(8'h90, DC, q);
        check("timer start", 32'(q == 16'h0003 || q == 16'h0002), 32'd1);
        for (n = 0; n < 30000 && evq.size() < 2; n++) @(posedge clk);
        check("timer period", evq[1] - evq[0], (3 + 1) * `HTCW_GPT_TICK_CYCLES);
        wr(8'h8e, 16'h0000);
        rd(8'h8c, 17'h0ffff, q);
        rd(8'h90, DC, a);
        wr(8'h90, 16'h1234);
        repeat (2600) @(posedge clk);
        rd(8'h90, DC, b);
        check("timer halted", b, a);
        check("timer quiet", evq.size(), 32'd2);
        wr(8'h98, 16'hffff);
        wr(8'h9a, 16'hffff);
        swp = 1'b1;
        rd(8'h8c, 17'h00000, q);
        rd(8'h8e, 17'h0ffff, q);
        wr(8'h98, 16'h0000);
        swp = 1'b0;
        wr(8'h98, 16'h0000);
        for (int i = 0; i < 6; i++)
            rd(ofs_tab[i], (i == 2) ? {1'b0, a} : {1'b0, rst_tab[i]}, q);
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            #1 rxh_v = 1'b1;
            rxh_d = 16'($random(seed));
            if (i[0]) rxq.push_back({rxh_d, a});
            a = rxh_d;
            @(posedge clk);
        end
        #1 rxh_v = 1'b0;
        for (int i = 0; i < 4; i++) begin
            txw_d = $random(seed);
            txw_v = 1'b1;
            txq.push_back(txw_d[15:0]);
            txq.push_back(txw_d[31:16]);
            for (n = 0; n < 100 && !txw_rdy; n++) @(negedge clk);
            @(posedge clk);
            #1 txw_v = 1'b0;
            @(posedge clk);
            #1;
        end
        for (n = 0; n < 200 && txq.size() > 0; n++) @(posedge clk);
        check("tx drained", txq.size(), 32'd0);
        check("halfway quiet", {31'h0, half_seen}, 32'd0);
        close_out();
    end
endmodule
bind htcw_top htcw_props u_props (.CLK(CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N),
    .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .GPT_EVENT(GPT_EVENT), .RXH_VALID(RXH_VALID),
    .RXH_DATA(RXH_DATA), .RXW_VALID(RXW_VALID), .RXW_DATA(RXW_DATA), .TXW_VALID(TXW_VALID),
    .TXW_DATA(TXW_DATA), .TXW_READY(TXW_READY), .TXH_VALID(TXH_VALID), .TXH_DATA(TXH_DATA),
    .TXH_READY(TXH_READY));
`default_nettype wire
